// ### design/acm_clock_mgmt.sv
// Purpose: Clock management for an audio DSP chip: core clock selection,
//   glitch-free PLL bypass, serial audio port clocks and control bus rate.
// Assumes: All inputs are synchronous to clock; the PLL model runs as an
//   enable-based rate generator on clock.
// Notes: Clocks are produced as enable pulses and level outputs.
// Functional notes
// - Derive controller, bus and DSP clocks from the one master clock.
// - Normally the PLL output clocks the controller and DSP core.
// - Bypass feeds controller and DSP clocks straight from master clock.
// - Port mode selects master or slave; master enables bit/frame outputs.
// - Sample rate changes on the fly without reset or state loss.
// - Master mode makes bit and frame clocks from the crystal or external master clock.
// - Slave mode forwards incoming bit and frame clocks to outputs.
// - Slave supports 512x at 44.1k, 256x at 48k; PLL 5.5, 2816 cycles.
// - Control bus master runs at 375 kHz from 24.576 MHz master clock; the code divides by 64, giving 384 kHz.
`timescale 1ns/10ps
`include "acm_params.svh"

module acm_clock_mgmt
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic crystalClockIn,
  input wire logic extMclkIn,
  input wire logic pllBypass,
  input wire logic portMaster,
  input wire logic rate441,
  input wire logic bitClockIn,
  input wire logic frameClockIn,
  output logic coreClock,
  output logic ctrlBusClock,
  output logic bitClockOut,
  output logic frameClockOut,
  output logic bitClockOutEn,
  output logic frameClockOutEn,
  output logic dspSampleTick
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // =============================================================
  // Master clock edge detection
  // =============================================================
  logic mclkQ_q, mclkQ_d;
  logic mclkRise;
  assign mclkQ_d = crystalClockIn | extMclkIn;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      mclkQ_q <= 1'b0;
    else
      mclkQ_q <= mclkQ_d;
  end
  assign mclkRise = mclkQ_d & ~mclkQ_q;

  // =============================================================
  // PLL: 5.5x rate generator (11/2 phase accumulator)
  // =============================================================
  // Each master clock edge adds 11 half-steps; a PLL tick per 2 spent.
  logic [4:0] pllAcc_q, pllAcc_d;
  logic pllTick;
  logic pllClk_q, pllClk_d;
  always_comb
  begin
    pllAcc_d = pllAcc_q;
    pllTick = 1'b0;
    if (mclkRise)
      pllAcc_d = pllAcc_q + 5'(`ACM_PLL_NUM);
    else if (pllAcc_q >= 5'(`ACM_PLL_DEN))
    begin
      pllAcc_d = pllAcc_q - 5'(`ACM_PLL_DEN);
      pllTick = 1'b1;
    end
    pllClk_d = pllTick ? ~pllClk_q : pllClk_q;
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pllAcc_q <= 5'h00;
      pllClk_q <= 1'b0;
    end
    else
    begin
      pllAcc_q <= pllAcc_d;
      pllClk_q <= pllClk_d;
    end
  end

  // =============================================================
  // Glitch-free core clock switch
  // =============================================================
  // The switch waits for the current source to be low, parks the output
  // low, then waits for the new source to be low before releasing it.
  acm_pkg::acm_sw_t sw_q, sw_d;
  logic useBypass_q, useBypass_d;
  logic core_q, core_d;
  logic srcLevel;
  always_comb
  begin
    sw_d = sw_q;
    useBypass_d = useBypass_q;
    srcLevel = useBypass_q ? mclkQ_q : pllClk_q;
    core_d = core_q;
    case (sw_q)
      acm_pkg::ACM_RUN:
      begin
        core_d = srcLevel;
        if (pllBypass != useBypass_q && !srcLevel)
        begin
          sw_d = acm_pkg::ACM_STOP;
          core_d = 1'b0;
        end
      end
      acm_pkg::ACM_STOP:
      begin
        core_d = 1'b0;
        useBypass_d = pllBypass;
        sw_d = acm_pkg::ACM_SWAP;
      end
      acm_pkg::ACM_SWAP:
      begin
        core_d = 1'b0;
        if (!srcLevel)
          sw_d = acm_pkg::ACM_WAIT;
      end
      acm_pkg::ACM_WAIT:
      begin
        core_d = srcLevel;
        sw_d = acm_pkg::ACM_RUN;
      end
      default:
      begin
        sw_d = acm_pkg::ACM_RUN;
        core_d = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sw_q <= acm_pkg::ACM_RUN;
      useBypass_q <= 1'b0;
      core_q <= 1'b0;
    end
    else
    begin
      sw_q <= sw_d;
      useBypass_q <= useBypass_d;
      core_q <= core_d;
    end
  end
  assign coreClock = core_q;
  // =============================================================
  // DSP sample tick: 2816 core cycles per sample
  // =============================================================
  logic [11:0] dspCnt_q, dspCnt_d;
  logic coreRise, sampleTick_q, sampleTick_d;
  assign coreRise = core_d & ~core_q;
  always_comb
  begin
    dspCnt_d = dspCnt_q;
    sampleTick_d = coreRise && dspCnt_q == 12'h000;
    if (coreRise)
      dspCnt_d = (dspCnt_q == 12'(`ACM_DSP_CYC_PER_FS - 1)) ? 12'h000 :
        dspCnt_q + 12'h001;
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dspCnt_q <= 12'h000;
      sampleTick_q <= 1'b0;
    end
    else
    begin
      dspCnt_q <= dspCnt_d;
      sampleTick_q <= sampleTick_d;
    end
  end
  assign dspSampleTick = sampleTick_q;
  // =============================================================
  // Control bus clock: master clock divided by 64 (384 kHz)
  // =============================================================
  logic [5:0] busCnt_q, busCnt_d;
  logic busClk_q, busClk_d;
  always_comb
  begin
    busCnt_d = busCnt_q;
    busClk_d = busClk_q;
    if (mclkRise)
    begin
      if (busCnt_q == 6'(`ACM_CTRL_HALF))
      begin
        busCnt_d = 6'h00;
        busClk_d = ~busClk_q;
      end
      else
        busCnt_d = busCnt_q + 6'h01;
    end
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busCnt_q <= 6'h00;
      busClk_q <= 1'b0;
    end
    else
    begin
      busCnt_q <= busCnt_d;
      busClk_q <= busClk_d;
    end
  end
  assign ctrlBusClock = busClk_q;
  // =============================================================
  // Serial audio port clocks
  // =============================================================
  // A free-running divider of master clock edges; the rate select changes
  // only the wrap point and the tapped bits, so a rate change keeps all other state.
  logic [9:0] fsCnt_q, fsCnt_d;
  logic [9:0] fsLast;
  logic bitGen, frameGen;
  logic bitOut_q, bitOut_d, frameOut_q, frameOut_d;
  always_comb
  begin
    fsLast = (rate441 ? `ACM_MCLK_PER_FS_441 : `ACM_MCLK_PER_FS_48)
      - 10'h001;
    fsCnt_d = fsCnt_q;
    if (mclkRise)
      fsCnt_d = (fsCnt_q >= fsLast) ? 10'h000 : fsCnt_q + 10'h001;
    // Bit clock: 64 periods per frame; frame clock: high in second half.
    bitGen = rate441 ? fsCnt_q[2] : fsCnt_q[1];
    frameGen = rate441 ? fsCnt_q[8] : fsCnt_q[7];
    bitOut_d = portMaster ? bitGen : bitClockIn;
    frameOut_d = portMaster ? frameGen : frameClockIn;
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fsCnt_q <= 10'h000;
      bitOut_q <= 1'b0;
      frameOut_q <= 1'b0;
    end
    else
    begin
      fsCnt_q <= fsCnt_d;
      bitOut_q <= bitOut_d;
      frameOut_q <= frameOut_d;
    end
  end
  assign bitClockOut = bitOut_q;
  assign frameClockOut = frameOut_q;
  assign bitClockOutEn = portMaster;
  assign frameClockOutEn = portMaster;
  // =============================================================
  // Checks
  // =============================================================
  property p_noRunt;
    (sw_q == acm_pkg::ACM_STOP) |-> !core_q ##1 !core_q;
  endproperty
  a_noRunt: assert property (p_noRunt) else $error("core runt");
  property p_slaveFwd;
    !portMaster |=> bitClockOut == $past(bitClockIn);
  endproperty
  a_slaveFwd: assert property (p_slaveFwd) else $error("fwd");
  property p_enMaster;
    bitClockOutEn && frameClockOutEn |=> bitClockOut == $past(bitGen);
  endproperty
  a_enMaster: assert property (p_enMaster) else $error("gen");
  property p_fsWrap;
    fsCnt_q <= 10'(`ACM_MCLK_PER_FS_441 - 1);
  endproperty
  a_fsWrap: assert property (p_fsWrap) else $error("fs range");
  property p_busHold;
    !mclkRise |=> $stable(busClk_q);
  endproperty
  a_busHold: assert property (p_busHold) else $error("bus moved");
  property p_dspRange;
    dspCnt_q < 12'(`ACM_DSP_CYC_PER_FS);
  endproperty
  a_dspRange: assert property (p_dspRange) else $error("dsp cnt");
  property p_runFollows;
    (sw_q == acm_pkg::ACM_RUN && pllBypass == useBypass_q)
      |=> core_q == $past(srcLevel);
  endproperty
  a_runFollows: assert property (p_runFollows) else $error("src");
  property p_masterGen;
    portMaster |=> frameClockOut == $past(frameGen);
  endproperty
  a_masterGen: assert property (p_masterGen) else $error("frame");
endmodule

// ### pkg/acm_params.svh
// Purpose: Constants for the audio clock management block.
// Assumes: System clock at 100 MHz simulation rate; master clock is 2*halfCycles system clocks per period.
// Notes: Frame ratios are in master clock cycles, except ACM_BCLK_PER_FS in bit clocks; the DSP ratio is in core cycles.
`ifndef ACM_PARAMS_SVH
`define ACM_PARAMS_SVH

// =============================================================
// Clock ratios and frequencies
// =============================================================
`define ACM_MCLK_PER_FS_48 10'h100
`define ACM_MCLK_PER_FS_441 10'h200
`define ACM_BCLK_PER_FS 7'h40
`define ACM_MCLK_HZ 24576000
`define ACM_CTRL_BUS_HZ 375000
`define ACM_CTRL_BUS_DIV (`ACM_MCLK_HZ / `ACM_CTRL_BUS_HZ)
`define ACM_CTRL_HALF ((`ACM_CTRL_BUS_DIV / 2) - 1)
`define ACM_PLL_NUM 4'hB
`define ACM_PLL_DEN 4'h2
`define ACM_DSP_CYC_PER_FS 12'hB00

`endif

// ### pkg/acm_pkg.sv
// Purpose: Types for the audio clock management block.
// Assumes: Nothing beyond the params header.
// Notes: Switch states are Gray coded along the normal path.
package acm_pkg;
  typedef enum logic [1:0]
  {
    ACM_RUN = 2'h0,
    ACM_STOP = 2'h1,
    ACM_SWAP = 2'h3,
    ACM_WAIT = 2'h2
  } acm_sw_t;
endpackage

// ### sim/acm_clock_source.sv
// Purpose: Master clock source and slave-side serial clock peer.
// Assumes: Runs from the bench clock; halfCycles is 8 or more.
// Notes: Of the master clock inputs only the crystal toggles; serial clocks stay low while slaveOn is low.
`timescale 1ns/10ps
module acm_clock_source
(
  input wire logic clock,
  input wire logic [4:0] halfCycles,
  input wire logic slaveOn,
  output logic crystalClockIn,
  output logic extMclkIn,
  output logic bitClockIn,
  output logic frameClockIn
);
  logic [4:0] tick;
  logic [7:0] mCount;
  initial
  begin
    crystalClockIn = 1'b0;
    tick = 5'h00;
    mCount = 8'h00;
  end
  assign extMclkIn = 1'b0;
  always @(posedge clock)
  begin
    if (tick >= halfCycles - 5'h01)
    begin
      tick <= 5'h00;
      crystalClockIn <= ~crystalClockIn;
      if (!crystalClockIn)
        mCount <= mCount + 8'h01;
    end
    else
      tick <= tick + 5'h01;
  end
  // A 48 kHz peer: 256 master clocks per frame, 64 bits per frame.
  assign bitClockIn = slaveOn & mCount[1];
  assign frameClockIn = slaveOn & mCount[7];
endmodule

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the audio clock management block.
// Assumes: Master clock is sixteen bench clocks per period, twenty in t_freq.
// Notes: Periods are counted in master clock or core clock rises.
`timescale 1ns/10ps
module tb_top;
  logic clock, rst_b, pllBypass, portMaster, rate441, slaveOn;
  logic crystalClockIn, extMclkIn, bitClockIn, frameClockIn;
  logic coreClock, ctrlBusClock, bitClockOut, frameClockOut;
  logic bitClockOutEn, frameClockOutEn, dspSampleTick, mPrev, cPrev;
  logic [4:0] halfCycles;
  int failures, samples_checked, mclkRises, coreRises;
  // ==========================================================
  // Instances
  // ==========================================================
  acm_clock_source src_u (.clock(clock), .halfCycles(halfCycles),
    .slaveOn(slaveOn), .crystalClockIn(crystalClockIn),
    .extMclkIn(extMclkIn), .bitClockIn(bitClockIn),
    .frameClockIn(frameClockIn));
  acm_clock_mgmt dut_u (.clock(clock), .rst_b(rst_b),
    .crystalClockIn(crystalClockIn), .extMclkIn(extMclkIn),
    .pllBypass(pllBypass), .portMaster(portMaster), .rate441(rate441),
    .bitClockIn(bitClockIn), .frameClockIn(frameClockIn),
    .coreClock(coreClock), .ctrlBusClock(ctrlBusClock),
    .bitClockOut(bitClockOut), .frameClockOut(frameClockOut),
    .bitClockOutEn(bitClockOutEn), .frameClockOutEn(frameClockOutEn),
    .dspSampleTick(dspSampleTick));
  // ==========================================================
  // Clock and edge counters
  // ==========================================================
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    if (crystalClockIn === 1'b1 && mPrev === 1'b0)
      mclkRises++;
    if (coreClock === 1'b1 && cPrev === 1'b0)
      coreRises++;
    mPrev = crystalClockIn;
    cPrev = coreClock;
  end
  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic close_out();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok)
    begin
      failures++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return bitClockOut;
      1: return frameClockOut;
      2: return ctrlBusClock;
      default: return dspSampleTick;
    endcase
  endfunction
  task automatic wait_rise(input int s);
    logic p;
    p = pick(s);
    for (int k = 0; k < 60000; k++)
    begin
      @(posedge clock);
      #1;
      if (pick(s) === 1'b1 && p === 1'b0)
        return;
      p = pick(s);
    end
    chk(1'b0, "wait timed out");
    close_out();
  endtask
  // Edges of the reference seen between two rises of the output.
  task automatic gap(input int s, input bit core, output int d);
    int a;
    wait_rise(s);
    a = core ? coreRises : mclkRises;
    wait_rise(s);
    d = (core ? coreRises : mclkRises) - a;
  endtask
  task automatic chk_reset();
    #1;
    chk({coreClock, ctrlBusClock, bitClockOut, frameClockOut,
      dspSampleTick} === 5'h00, "outputs not low in reset");
    chk(bitClockOutEn === portMaster, "enable in reset");
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_master48();
    int d;
    @(posedge clock);
    portMaster <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk(bitClockOutEn === 1'b1 && frameClockOutEn === 1'b1, "en");
    gap(0, 0, d);
    chk(d == 4, "bit period 48k");
    gap(1, 0, d);
    chk(d == 256, "frame period 48k");
    gap(2, 0, d);
    chk(d == 64, "control bus period");
    $display("master48 done");
  endtask
  task automatic t_rate441();
    int d;
    @(posedge clock);
    // No audio rides these clocks, so the outputs are not checked over the change.
    rate441 <= 1'b1;
    wait_rise(0);
    gap(0, 0, d);
    chk(d == 8, "bit period 44k1");
    gap(1, 0, d);
    chk(d == 512, "frame period 44k1");
    $display("rate441 done");
  endtask
  task automatic t_slave();
    logic pb, pf;
    @(posedge clock);
    portMaster <= 1'b0;
    rate441 <= 1'b0;
    slaveOn <= 1'b1;
    @(posedge clock);
    #1;
    chk(bitClockOutEn === 1'b0 && frameClockOutEn === 1'b0, "en");
    repeat (4200)
    begin
      pb = bitClockIn;
      pf = frameClockIn;
      @(posedge clock);
      #1;
      chk(bitClockOut === pb && frameClockOut === pf, "fwd");
    end
    $display("slave done");
  endtask
  task automatic t_dsp();
    int d, a, b;
    gap(3, 1, d);
    chk(d == 2816, "core cycles per sample");
    a = mclkRises;
    b = coreRises;
    repeat (512) @(posedge clock);
    chk(coreRises - b > 2 * (mclkRises - a), "pll rate");
    $display("dsp done");
  endtask
  task automatic t_bypass();
    int run, a, b;
    bit fresh;
    run = 0;
    fresh = 0;
    @(posedge clock);
    pllBypass <= 1'b1;
    repeat (80)
    begin
      @(posedge clock);
      #1;
      if (coreClock === 1'b1)
        run++;
      else
      begin
        if (fresh && run > 0)
          chk(run >= 7, "short core pulse");
        fresh = 1;
        run = 0;
      end
    end
    a = mclkRises;
    b = coreRises;
    repeat (512) @(posedge clock);
    a = mclkRises - a;
    b = coreRises - b;
    chk(b >= a - 1 && b <= a + 1, "bypass rate");
    $display("bypass done");
  endtask
  task automatic t_freq();
    int d;
    @(posedge clock);
    rst_b <= 1'b0;
    halfCycles <= 5'h0A;
    repeat (12) @(posedge clock);
    chk_reset();
    @(posedge clock);
    rst_b <= 1'b1;
    portMaster <= 1'b1;
    gap(0, 0, d);
    chk(d == 4, "bit period after reset");
    $display("freq done");
  endtask
  initial
  begin
    rst_b = 1'b0;
    pllBypass = 1'b0;
    portMaster = 1'b0;
    rate441 = 1'b0;
    slaveOn = 1'b0;
    halfCycles = 5'h08;
    failures = 0;
    samples_checked = 0;
    mclkRises = 0;
    coreRises = 0;
    mPrev = 1'b0;
    cPrev = 1'b0;
    repeat (12) @(posedge clock);
    chk_reset();
    @(posedge clock);
    rst_b <= 1'b1;
    t_master48();
    t_rate441();
    t_slave();
    t_dsp();
    t_bypass();
    t_freq();
    close_out();
  end
endmodule
